// ==== bench/can_transceiver_wake_fault_ctrl_tb_top.sv ====
// Testbench for cwf_ctrl: wake detection, rearming and fault supervision.
// Assumes the host model drives pins and modes; checker is bound to the design.
`timescale 1ns/1ns
`default_nettype none
module can_transceiver_wake_fault_ctrl_tb_top;
  import cwf_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn;
  logic wdog_on_bus_wake;
  logic wdog_enabled;
  logic clr_wake, clr_fault, clr_uv;
  logic bus_rx, transmit_input, transceiver_supply_ok;
  cwf_trx_mode_t trx_mode_cmd, trx_mode;
  cwf_sys_mode_t sys_mode;
  logic receive_output, bus_drive, tx_disabled, bus_wake_flag, wake_source_status;
  logic bus_fault_flag, transceiver_supply_low_flag, wake_int, wdog_enable_req, sys_restart_req;
  int err_count = 0;
  int checks = 0;
  int n_int = 0;
  int n_wd = 0;
  int n_rst = 0;
  always #20 sys_clk = ~sys_clk;
  cwf_host_model cwf_host_model_i (.sys_clk(sys_clk), .bus_rx(bus_rx),
    .transmit_input(transmit_input), .transceiver_supply_ok(transceiver_supply_ok),
    .trx_mode_cmd(trx_mode_cmd), .sys_mode(sys_mode));
  cwf_ctrl cwf_ctrl_i (.sys_clk(sys_clk), .resetn(resetn), .transmit_input(transmit_input),
    .bus_rx(bus_rx), .transceiver_supply_ok(transceiver_supply_ok),
    .trx_mode_cmd(trx_mode_cmd), .sys_mode(sys_mode), .wdog_on_bus_wake(wdog_on_bus_wake),
    .wdog_enabled(wdog_enabled), .bus_wake_flag_clr(clr_wake), .bus_fault_flag_clr(clr_fault),
    .supply_low_flag_clr(clr_uv), .trx_mode(trx_mode), .receive_output(receive_output),
    .bus_drive(bus_drive), .tx_disabled(tx_disabled), .bus_wake_flag(bus_wake_flag),
    .wake_source_status(wake_source_status), .bus_fault_flag(bus_fault_flag),
    .transceiver_supply_low_flag(transceiver_supply_low_flag), .wake_int(wake_int),
    .wdog_enable_req(wdog_enable_req), .sys_restart_req(sys_restart_req));
  // Pulse counters
  always @(posedge sys_clk) begin
    if (wake_int === 1'b1) n_int <= n_int + 1;
    if (wdog_enable_req === 1'b1) n_wd <= n_wd + 1;
    if (sys_restart_req === 1'b1) n_rst <= n_rst + 1;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // Pulses only the selected flag clears for one cycle
  task automatic clear(input logic w, input logic f, input logic u);
    clr_wake = w;
    clr_fault = f;
    clr_uv = u;
    cyc(1);
    clr_wake = 1'b0;
    clr_fault = 1'b0;
    clr_uv = 1'b0;
  endtask : clear
  task automatic t_off_short;
    chk(trx_mode === CWF_TRX_OFF && receive_output === 1'b1 && tx_disabled === 1'b1, "reset");
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(bus_wake_flag === 1'b0, "wake taken in Off");
    cwf_host_model_i.cmd(CWF_TRX_WAKE, CWF_SYS_NORMAL);
    cwf_host_model_i.wake_pattern(10);
    cyc(8);
    chk(bus_wake_flag === 1'b0 && receive_output === 1'b1, "short phases woke");
    $display("test off_short done");
  endtask : t_off_short
  task automatic t_wake_rearm;
    int i;
    i = n_int;
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(bus_wake_flag === 1'b1 && wake_source_status === 1'b1 && n_int == i + 1, "flags");
    chk(receive_output === 1'b0 && trx_mode === CWF_TRX_WAKE, "rx low, mode kept");
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_int == i + 1 && receive_output === 1'b0, "woke again unarmed");
    cwf_host_model_i.cmd(CWF_TRX_RXO, CWF_SYS_NORMAL);
    chk(receive_output === 1'b1, "rx not released");
    cwf_host_model_i.cmd(CWF_TRX_WAKE, CWF_SYS_NORMAL);
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_int == i + 2 && bus_wake_flag === 1'b1, "toggle did not rearm");
    $display("test wake_rearm done");
  endtask : t_wake_rearm
  task automatic t_sys_wake;
    int i, w, r;
    i = n_int;
    w = n_wd;
    r = n_rst;
    wdog_on_bus_wake = 1'b1;
    wdog_enabled = 1'b0;
    cwf_host_model_i.cmd(CWF_TRX_WAKE, CWF_SYS_STOP);
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_int == i + 1 && n_wd == w + 1 && n_rst == r, "stop wake");
    wdog_enabled = 1'b1;
    cwf_host_model_i.cmd(CWF_TRX_WAKE, CWF_SYS_SLEEP);
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_rst == r + 1 && n_int == i + 1 && receive_output === 1'b0, "sleep wake");
    chk(n_wd == w + 1, "watchdog request with watchdog on");
    cwf_host_model_i.cmd(CWF_TRX_OFF, CWF_SYS_FAILSAFE);
    chk(trx_mode === CWF_TRX_WAKE, "fail-safe mode");
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_rst == r + 2 && n_int == i + 1, "fail-safe wake");
    cwf_host_model_i.cmd(CWF_TRX_RXO, CWF_SYS_RESTART);
    cwf_host_model_i.cmd(CWF_TRX_WAKE, CWF_SYS_RESTART);
    cwf_host_model_i.wake_pattern(100);
    cyc(8);
    chk(n_rst == r + 3 && n_int == i + 1 && receive_output === 1'b0, "restart wake");
    $display("test sys_wake done");
  endtask : t_sys_wake
  task automatic t_faults;
    cwf_host_model_i.cmd(CWF_TRX_NORM, CWF_SYS_NORMAL);
    clear(1'b1, 1'b1, 1'b0);
    chk(bus_wake_flag === 1'b0 && wake_source_status === 1'b0, "wake flag kept");
    cwf_host_model_i.pins(1'b0, 1'b1);
    cyc(TX_DOM_CYC - 100);
    chk(tx_disabled === 1'b0 && bus_fault_flag === 1'b0, "early time-out");
    chk(bus_drive === 1'b1, "dominant not driven");
    cyc(120);
    chk(tx_disabled === 1'b1 && bus_fault_flag === 1'b1, "no time-out");
    chk(bus_drive === 1'b0, "driven after time-out");
    cwf_host_model_i.pins(1'b1, 1'b1);
    cyc(10);
    chk(tx_disabled === 1'b0 && trx_mode === CWF_TRX_NORM, "not restored");
    cwf_host_model_i.cmd(CWF_TRX_RXO, CWF_SYS_NORMAL);
    clear(1'b0, 1'b1, 1'b0);
    chk(bus_fault_flag === 1'b0, "fault flag kept");
    cwf_host_model_i.hold(1'b0, BUS_DOM_CYC + 20);
    chk(bus_fault_flag === 1'b1 && trx_mode === CWF_TRX_RXO, "bus clamp");
    chk(bus_drive === 1'b0 && receive_output === 1'b0, "receive only path");
    cwf_host_model_i.hold(1'b1, 4);
    cwf_host_model_i.cmd(CWF_TRX_NORM, CWF_SYS_NORMAL);
    cwf_host_model_i.pins(1'b1, 1'b0);
    cyc(8);
    chk(transceiver_supply_low_flag === 1'b1 && tx_disabled === 1'b1, "undervoltage");
    cwf_host_model_i.pins(1'b1, 1'b1);
    cyc(8);
    chk(tx_disabled === 1'b0 && trx_mode === CWF_TRX_NORM, "supply recovery");
    cwf_host_model_i.cmd(CWF_TRX_OFF, CWF_SYS_NORMAL);
    clear(1'b0, 1'b0, 1'b1);
    chk(transceiver_supply_low_flag === 1'b0 && bus_fault_flag === 1'b1, "clears not separate");
    cwf_host_model_i.pins(1'b1, 1'b0);
    cyc(8);
    chk(transceiver_supply_low_flag === 1'b0, "supply watched in Off");
    cwf_host_model_i.pins(1'b1, 1'b1);
    $display("test faults done");
  endtask : t_faults
  initial begin
    resetn = 1'b0;
    wdog_on_bus_wake = 1'b0;
    wdog_enabled = 1'b1;
    clr_wake = 1'b0;
    clr_fault = 1'b0;
    clr_uv = 1'b0;
    cyc(20);
    resetn = 1'b1;
    cyc(1);
    t_off_short;
    t_wake_rearm;
    t_sys_wake;
    t_faults;
    final_report;
  end
  initial begin
    #(40 * 70000);
    err_count++;
    final_report;
  end
endmodule : can_transceiver_wake_fault_ctrl_tb_top
`default_nettype wire

// ==== bench/cwf_ctrl_chk.sv ====
// Port assertions for the transceiver wake and fault control block.
// Assumes binding onto cwf_ctrl; cycle limits come from cwf_pkg.
`timescale 1ns/1ns
`default_nettype none
module cwf_ctrl_chk (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   transmit_input,
  input wire logic                   transceiver_supply_ok,
  input wire cwf_pkg::cwf_trx_mode_t trx_mode_cmd,
  input wire cwf_pkg::cwf_sys_mode_t sys_mode,
  input wire cwf_pkg::cwf_trx_mode_t trx_mode,
  input wire logic                   receive_output,
  input wire logic                   bus_drive,
  input wire logic                   tx_disabled,
  input wire logic                   bus_wake_flag,
  input wire logic                   wake_source_status,
  input wire logic                   bus_fault_flag,
  input wire logic                   wake_int,
  input wire logic                   sys_restart_req
);
  import cwf_pkg::*;
  logic [15:0] tx_cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Dominant transmit cycles seen while in Normal
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      tx_cnt_r <= 16'h0;
    else if (transmit_input || trx_mode != CWF_TRX_NORM)
      tx_cnt_r <= 16'h0;
    else if (tx_cnt_r != 16'hFFFF)
      tx_cnt_r <= tx_cnt_r + 16'h1;
  end
  a_wake_needs_mode: assert property (
    $rose(bus_wake_flag) |-> $past(trx_mode) == CWF_TRX_WAKE)
    else $error("wake flag set outside wake capable mode");
  a_rx_low_held: assert property (
    (trx_mode == CWF_TRX_WAKE && !receive_output) |=> (trx_mode != CWF_TRX_WAKE || !receive_output))
    else $error("receive output released while still wake capable");
  a_int_sys_mode: assert property (
    wake_int |-> ($past(sys_mode) == CWF_SYS_NORMAL || $past(sys_mode) == CWF_SYS_STOP))
    else $error("wake interrupt outside Normal or Stop");
  a_int_with_flags: assert property (
    wake_int |-> bus_wake_flag && wake_source_status && !receive_output ##1 !wake_int)
    else $error("wake interrupt without status or longer than one cycle");
  a_restart_mode: assert property (
    sys_restart_req |-> $past(sys_mode) inside {CWF_SYS_SLEEP, CWF_SYS_RESTART, CWF_SYS_FAILSAFE})
    else $error("restart request from Normal or Stop");
  a_rxo_no_drive: assert property (
    (trx_mode == CWF_TRX_RXO && $past(trx_mode) == CWF_TRX_RXO) |-> !bus_drive)
    else $error("bus driven in receive only");
  a_fs_forces_wake: assert property (
    $past(sys_mode) == CWF_SYS_FAILSAFE |-> trx_mode == CWF_TRX_WAKE)
    else $error("fail-safe did not force wake capable");
  a_mode_follows: assert property (
    $past(sys_mode) != CWF_SYS_FAILSAFE |-> trx_mode == $past(trx_mode_cmd))
    else $error("mode field does not follow command");
  a_txd_timeout: assert property (
    tx_cnt_r == 16'(TX_DOM_CYC + 8) |-> tx_disabled && bus_fault_flag)
    else $error("transmit time-out not taken");
  a_tx_release: assert property (
    $rose(transmit_input) ##0 (transceiver_supply_ok && trx_mode == CWF_TRX_NORM)[*8] |-> !tx_disabled)
    else $error("transmitter not restored");
endmodule : cwf_ctrl_chk
bind cwf_ctrl cwf_ctrl_chk cwf_ctrl_chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .transmit_input(transmit_input),
  .transceiver_supply_ok(transceiver_supply_ok), .trx_mode_cmd(trx_mode_cmd),
  .sys_mode(sys_mode), .trx_mode(trx_mode), .receive_output(receive_output),
  .bus_drive(bus_drive), .tx_disabled(tx_disabled), .bus_wake_flag(bus_wake_flag),
  .wake_source_status(wake_source_status), .bus_fault_flag(bus_fault_flag),
  .wake_int(wake_int), .sys_restart_req(sys_restart_req));
`default_nettype wire

// ==== bench/cwf_host_model.sv ====
// Host and bus model: mode commands, transmit pin, supply and bus level.
// Assumes callers enter its tasks at the falling edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none
module cwf_host_model (
  input  wire logic              sys_clk,
  output var logic               bus_rx,
  output var logic               transmit_input,
  output var logic               transceiver_supply_ok,
  output cwf_pkg::cwf_trx_mode_t trx_mode_cmd,
  output cwf_pkg::cwf_sys_mode_t sys_mode
);
  import cwf_pkg::*;
  initial begin
    bus_rx = 1'b1;
    transmit_input = 1'b1;
    transceiver_supply_ok = 1'b1;
    trx_mode_cmd = CWF_TRX_OFF;
    sys_mode = CWF_SYS_NORMAL;
  end
  task automatic hold(input logic lvl, input int n);
    bus_rx = lvl;
    repeat (n) @(negedge sys_clk);
  endtask : hold
  // Dominant, recessive, dominant, then idle recessive
  task automatic wake_pattern(input int n);
    hold(1'b0, n);
    hold(1'b1, n);
    hold(1'b0, n);
    hold(1'b1, 2);
  endtask : wake_pattern
  // Host leaves wake capable and returns to rearm; it alone moves Stop to Normal
  task automatic cmd(input cwf_trx_mode_t m, input cwf_sys_mode_t s);
    trx_mode_cmd = m;
    sys_mode = s;
    repeat (4) @(negedge sys_clk);
  endtask : cmd
  task automatic pins(input logic t, input logic s);
    transmit_input = t;
    transceiver_supply_ok = s;
  endtask : pins
endmodule : cwf_host_model
`default_nettype wire

// ==== rtl/cwf_ctrl.sv ====
// Transceiver mode, wake-pattern detection and fault supervision control.
// Assumes mode commands come from the SPI block on sys_clk; bus and pins are async.
//
// How it works
// - Wake capable allowed in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// - Bus wake drives receive output low until another transceiver mode.
// - Wake pattern: dominant, recessive, dominant, each between min and max.
// - After wake, mode field still reads wake capable; receive stays low.
// - Leaving wake capable then returning rearms wake detection.
// - System change to Stop, Sleep or Fail-Safe rearms wake automatically.
// - Rearming does not need the wake flag cleared.
// - In Stop or Normal, wake raises interrupt, records source, drops receive.
// - No automatic Stop to Normal after a wake; host commands it.
// - Wake in Stop re-enables a disabled watchdog when wake-enable set.
// - Wake in Sleep requests Restart then Normal; receive goes low.
// - Wake from Sleep gives no interrupt.
// - Normal/Stop keep mode; Sleep/Restart/Fail-Safe go to Restart.
// - After wake, host may command Normal mode; accepted.
// - Transmit dominant too long in Normal: driver off, receive only, fault.
// - When transmit time-out clears, driver returns; configuration unchanged.
// - Bus dominant too long in Normal or Receive Only sets fault flag.
// - Supply monitored only in Normal/Receive Only and system Normal/Stop.
// - Supply low sets flag, disables driver; recovery restores Normal.
// - Off mode after reset; wake events ignored there.
// - Receive Only keeps driver off, receive path working.
`timescale 1ns/1ns
`default_nettype none
module cwf_ctrl
  import cwf_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Pins from outside the clock domain
  input  wire logic                   transmit_input,
  input  wire logic                   bus_rx,
  input  wire logic                   transceiver_supply_ok,
  // Control from the SPI block
  input  wire cwf_pkg::cwf_trx_mode_t trx_mode_cmd,
  input  wire cwf_pkg::cwf_sys_mode_t sys_mode,
  input  wire logic                   wdog_on_bus_wake,
  input  wire logic                   wdog_enabled,
  input  wire logic                   bus_wake_flag_clr,
  input  wire logic                   bus_fault_flag_clr,
  input  wire logic                   supply_low_flag_clr,
  // Status and actions
  output cwf_pkg::cwf_trx_mode_t      trx_mode,
  output logic                        receive_output,
  output logic                        bus_drive,
  output logic                        tx_disabled,
  output logic                        bus_wake_flag,
  output logic                        wake_source_status,
  output logic                        bus_fault_flag,
  output logic                        transceiver_supply_low_flag,
  output logic                        wake_int,
  output logic                        wdog_enable_req,
  output logic                        sys_restart_req
);
  import cwf_pkg::*;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = n[CNT_W-1:0];
  endfunction : cyc

  // Phase length lies strictly between the wake limits
  function automatic logic in_window(input logic [CNT_W-1:0] c);
    in_window = (c > cyc(WAKE_MIN_CYC)) && (c < cyc(WAKE_MAX_CYC));
  endfunction : in_window

  logic txd_s;
  logic rx_s;
  logic vok_s;

  cwf_sync u_sync_txd (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (transmit_input),
    .q       (txd_s)
  );

  cwf_sync u_sync_rx (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (bus_rx),
    .q       (rx_s)
  );

  cwf_sync u_sync_vok (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (transceiver_supply_ok),
    .q       (vok_s)
  );

  // Mode requested, with Fail-Safe forcing wake capable
  cwf_trx_mode_t mode_eff;
  logic          wake_ok_sys;
  always_comb begin
    wake_ok_sys = (sys_mode == CWF_SYS_STOP) || (sys_mode == CWF_SYS_SLEEP) ||
                  (sys_mode == CWF_SYS_RESTART) || (sys_mode == CWF_SYS_NORMAL) ||
                  (sys_mode == CWF_SYS_FAILSAFE);
    if (sys_mode == CWF_SYS_FAILSAFE)
      mode_eff = CWF_TRX_WAKE;
    else
      mode_eff = trx_mode_cmd;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      trx_mode <= CWF_TRX_OFF;
    else
      trx_mode <= mode_eff;
  end

  cwf_sys_mode_t sys_mode_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      sys_mode_r <= CWF_SYS_NORMAL;
    else
      sys_mode_r <= sys_mode;
  end

  logic rearm;
  logic sys_rearm;
  assign sys_rearm = (sys_mode != sys_mode_r) &&
                     ((sys_mode == CWF_SYS_STOP) || (sys_mode == CWF_SYS_SLEEP) ||
                      (sys_mode == CWF_SYS_FAILSAFE));
  // Leaving wake capable rearms; the wake flag plays no part
  assign rearm = sys_rearm || (trx_mode != CWF_TRX_WAKE);

  // Wake-pattern detector
  cwf_wp_state_t    wp_r;
  logic [CNT_W-1:0] ph_cnt_r;
  logic             rx_prev_r;
  logic             wake_armed;
  logic             wake_hit;

  assign wake_armed = (trx_mode == CWF_TRX_WAKE) && wake_ok_sys;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      rx_prev_r <= 1'b1;
    else
      rx_prev_r <= rx_s;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      ph_cnt_r <= '0;
    else if (rx_s != rx_prev_r)
      ph_cnt_r <= cyc(1);
    else if (ph_cnt_r != cyc(WAKE_MAX_CYC))
      ph_cnt_r <= ph_cnt_r + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= CWF_WP_IDLE;
    end else if (rearm || !wake_armed) begin
      wp_r <= CWF_WP_IDLE;
    end else begin
      case (wp_r)
        CWF_WP_IDLE: begin
          if (!rx_s && rx_prev_r)
            wp_r <= CWF_WP_DOM1;
        end
        CWF_WP_DOM1: begin
          if (rx_s && !rx_prev_r)
            wp_r <= in_window(ph_cnt_r) ? CWF_WP_REC : CWF_WP_IDLE;
          else if (ph_cnt_r == cyc(WAKE_MAX_CYC))
            wp_r <= CWF_WP_IDLE;
        end
        CWF_WP_REC: begin
          if (!rx_s && rx_prev_r)
            wp_r <= in_window(ph_cnt_r) ? CWF_WP_DOM2 : CWF_WP_DOM1;
          else if (ph_cnt_r == cyc(WAKE_MAX_CYC))
            wp_r <= CWF_WP_IDLE;
        end
        CWF_WP_DOM2: begin
          if (rx_s && !rx_prev_r)
            wp_r <= in_window(ph_cnt_r) ? CWF_WP_DONE : CWF_WP_IDLE;
          else if (ph_cnt_r == cyc(WAKE_MAX_CYC))
            wp_r <= CWF_WP_IDLE;
        end
        CWF_WP_DONE: begin
          wp_r <= CWF_WP_DONE;
        end
        default: wp_r <= CWF_WP_IDLE;
      endcase
    end
  end

  // One pulse on entry to DONE
  assign wake_hit = wake_armed && (wp_r == CWF_WP_DOM2) && rx_s && !rx_prev_r &&
                    in_window(ph_cnt_r) && !rearm;

  // Wake latch holds receive low until the mode changes
  logic woken_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      woken_r <= 1'b0;
    else if (wake_hit)
      woken_r <= 1'b1;
    else if (trx_mode != CWF_TRX_WAKE || mode_eff != CWF_TRX_WAKE)
      woken_r <= 1'b0;
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_wake_flag      <= 1'b0;
      wake_source_status <= 1'b0;
    end else if (wake_hit) begin
      bus_wake_flag      <= 1'b1;
      wake_source_status <= 1'b1;
    end else if (bus_wake_flag_clr) begin
      bus_wake_flag      <= 1'b0;
      wake_source_status <= 1'b0;
    end
  end

  // System actions on a wake; the system mode itself is never changed here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_int        <= 1'b0;
      sys_restart_req <= 1'b0;
      wdog_enable_req <= 1'b0;
    end else begin
      // Interrupt only when staying in Normal or Stop; never from Sleep
      wake_int <= wake_hit && ((sys_mode == CWF_SYS_NORMAL) ||
                               (sys_mode == CWF_SYS_STOP));
      sys_restart_req <= wake_hit && ((sys_mode == CWF_SYS_SLEEP) ||
                                      (sys_mode == CWF_SYS_RESTART) ||
                                      (sys_mode == CWF_SYS_FAILSAFE));
      wdog_enable_req <= wake_hit && (sys_mode == CWF_SYS_STOP) &&
                         !wdog_enabled && wdog_on_bus_wake;
    end
  end

  // Fault supervision
  logic txd_to;
  logic bus_to;
  logic tx_mon;
  logic bus_mon;
  logic uv_mon;
  logic uv_now;

  assign tx_mon  = (trx_mode == CWF_TRX_NORM) && !txd_s;
  assign bus_mon = ((trx_mode == CWF_TRX_NORM) || (trx_mode == CWF_TRX_RXO)) && !rx_s;
  assign uv_mon  = ((trx_mode == CWF_TRX_NORM) || (trx_mode == CWF_TRX_RXO)) &&
                   ((sys_mode == CWF_SYS_NORMAL) || (sys_mode == CWF_SYS_STOP));
  assign uv_now  = uv_mon && !vok_s;

  cwf_dom_timer u_txd_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .active  (tx_mon),
    .limit   (cyc(TX_DOM_CYC)),
    .expired (txd_to)
  );

  cwf_dom_timer u_bus_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .active  (bus_mon),
    .limit   (cyc(BUS_DOM_CYC)),
    .expired (bus_to)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      bus_fault_flag <= 1'b0;
    else if (txd_to || bus_to)
      bus_fault_flag <= 1'b1;
    else if (bus_fault_flag_clr)
      bus_fault_flag <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      transceiver_supply_low_flag <= 1'b0;
    else if (uv_now)
      transceiver_supply_low_flag <= 1'b1;
    else if (supply_low_flag_clr)
      transceiver_supply_low_flag <= 1'b0;
  end

  // Driver and receive pin; timers release when the cause clears
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_disabled    <= 1'b1;
      bus_drive      <= 1'b0;
      receive_output <= 1'b1;
    end else begin
      tx_disabled <= (trx_mode != CWF_TRX_NORM) || txd_to || uv_now;
      bus_drive   <= (trx_mode == CWF_TRX_NORM) && !txd_to && !uv_now && !txd_s;
      if (trx_mode == CWF_TRX_WAKE)
        receive_output <= !(woken_r || wake_hit);
      else if (trx_mode == CWF_TRX_OFF)
        receive_output <= 1'b1;
      else
        receive_output <= rx_s;
    end
  end

endmodule : cwf_ctrl
`default_nettype wire

// ==== rtl/cwf_dom_timer.sv ====
// Saturating timer that flags a level held longer than a cycle limit.
// Assumes a synchronous level input and a static limit.
`timescale 1ns/1ns
`default_nettype none
module cwf_dom_timer
  import cwf_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             active,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else if (!active) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else begin
      if (cnt_r != limit)
        cnt_r <= cnt_r + 1'b1;
      // Held strictly longer than the limit
      expired <= (cnt_r == limit);
    end
  end
endmodule : cwf_dom_timer
`default_nettype wire

// ==== rtl/cwf_pkg.sv ====
// Constants and types shared by the transceiver wake and fault control block.
// Assumes a 25 MHz system clock; times are given in microseconds.
package cwf_pkg;

  localparam int unsigned CLK_MHZ = 25;

  // Filter and time-out figures, in microseconds
  localparam int unsigned WAKE_MIN_TIME_US    = 1;
  localparam int unsigned WAKE_MAX_TIME_US    = 1000;
  localparam int unsigned TX_DOM_TIMEOUT_US   = 1000;
  localparam int unsigned BUS_DOM_TIMEOUT_US  = 1000;

  // Cycle counts: least times round up, longest times round down
  localparam int unsigned WAKE_MIN_CYC   = WAKE_MIN_TIME_US * CLK_MHZ;
  localparam int unsigned WAKE_MAX_CYC   = WAKE_MAX_TIME_US * CLK_MHZ;
  localparam int unsigned TX_DOM_CYC     = TX_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned BUS_DOM_CYC    = BUS_DOM_TIMEOUT_US * CLK_MHZ;

  localparam int unsigned CNT_W = 16;

  // Transceiver mode field encodings
  typedef enum logic [1:0] {
    CWF_TRX_OFF   = 2'h0,
    CWF_TRX_WAKE  = 2'h1,
    CWF_TRX_RXO   = 2'h2,
    CWF_TRX_NORM  = 2'h3
  } cwf_trx_mode_t;

  // System mode encodings
  typedef enum logic [2:0] {
    CWF_SYS_NORMAL   = 3'h0,
    CWF_SYS_STOP     = 3'h1,
    CWF_SYS_SLEEP    = 3'h2,
    CWF_SYS_RESTART  = 3'h3,
    CWF_SYS_FAILSAFE = 3'h4
  } cwf_sys_mode_t;

  // Wake-pattern detector states
  typedef enum logic [4:0] {
    CWF_WP_IDLE = 5'h01,
    CWF_WP_DOM1 = 5'h02,
    CWF_WP_REC  = 5'h04,
    CWF_WP_DOM2 = 5'h08,
    CWF_WP_DONE = 5'h10
  } cwf_wp_state_t;

endpackage : cwf_pkg

// ==== rtl/cwf_sync.sv ====
// Two-flop synchroniser for a single level arriving from a pin.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module cwf_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : cwf_sync
`default_nettype wire
